/* File: msd_delivery.sv */
// interrupt, nmi and smi delivery logic of the system controller
//
// Overview of operation
// - pins in wire mode, messages once router enabled
// - interrupt event sets its pending request bit
// - flush upstream writes before each message
// - each interrupt is one 32-bit write
// - address: fee, destination, zero reserved bits
// - address bit3 hint, bit2 destination mode
// - data bit15 trigger mode, top half zero
// - data bit14 assert status, 13:11 zero
// - data delivery mode from entry, low vector
// - system error gives nmi only if enabled
// - index port bit7 set blocks every nmi
// - mask register write only, resets masked
// - port 74h reads index, bit7 zero
// - index bits never affect nmi masking
// - sleep write raises smi when trap enabled
// - sleep write sets sleep trap status
// - end-of-smi write releases smi and rearms
// - pending enabled status retriggers after end-of-smi
// - status sets unenabled, software clears it
`timescale 1ns/10ps
`include "msd_consts.svh"
module msd_delivery
   import msd_pkg::*;
#(
   parameter int NIRQ = 8,
   parameter int IDXW = 3,
   parameter logic [15:0] EVT_BASE = `MSD_EVT_BASE_RST
) (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic [15:0] io_addr_i,
   input wire logic io_wr_i,
   input wire logic io_rd_i,
   input wire logic [31:0] io_wdata_i,
   output logic [31:0] io_rdata_o,
   input wire logic rte_wr_i,
   input wire logic [IDXW-1:0] rte_idx_i,
   input wire logic [63:0] rte_wdata_i,
   input wire logic [NIRQ-1:0] irq_i,
   input wire logic router_en_i,
   input wire logic maskable_irq_pin_ack_i,
   output logic flush_req_o,
   input wire logic flush_done_i,
   output logic msg_wr_o,
   output logic [31:0] msg_addr_o,
   output logic [31:0] msg_data_o,
   input wire logic msg_ack_i,
   output logic maskable_irq_pin_o,
   output logic nmi_o,
   input wire logic system_error_i,
   input wire logic legacy_nmi_i,
   input wire logic sleep_entry_wr_i,
   output logic smi_n_o
);

   ////////////////////////////////////////////////////////////////////////////
   // state

   // one packed struct, so ce_i freezes every bit through a single enable
   typedef struct packed {
      logic [NIRQ-1:0][63:0] rte;
      logic [NIRQ-1:0] irq_prev;
      logic [NIRQ-1:0] pend;
      msd_state_e st;
      logic [IDXW-1:0] cur;
      logic flush_req;
      logic msg_wr;
      logic [31:0] maddr;
      logic [31:0] mdata;
      logic maskable_irq_pin_pin;
      logic nmi;
      logic [7:0] nmi_idx;
      logic system_error_signal_en;
      logic system_error_signal_sts;
      logic sleep_entry_control;
      logic slp_sts;
      logic armed;
      logic smi_n;
      logic [31:0] rdata;
   } msd_state_s;

   msd_state_s q;
   msd_state_s d;
   logic [1:0] rst_sync_q;
   logic rst_n;
   logic [NIRQ-1:0] edge_set;
   logic [NIRQ-1:0] deliverable;
   logic [5:0] pick_msg;
   logic [5:0] pick_ack;
   logic [31:0] pad_msg;
   logic [31:0] pad_ack;
   logic wr_nmi_sc;
   logic wr_nmi_idx;
   logic wr_smi_en;
   logic wr_smi_sts;
   logic smi_cause;

   msd_msg_if msg ();

   ////////////////////////////////////////////////////////////////////////////
   // reset release, two stages so release is clean against mclk_i
   // ce_i does not gate this pair, so reset always leaves on time

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   ////////////////////////////////////////////////////////////////////////////
   // message formatter fed with the entry being delivered
   // the formatter is pure wiring; its word is only captured when the flush ends

   assign msg.rte = q.rte[q.cur];

   msd_msg_fmt u_fmt (
      .m (msg.fmt)
   );

   ////////////////////////////////////////////////////////////////////////////
   // decode and selection helpers

   // rising edges only, so a held level request is counted once
   // irq_prev resets low, so an input already high at release is one event
   assign edge_set = irq_i & ~q.irq_prev;

   // masked entries stay pending but are never sent as messages
   // the mask is not applied in wire mode: every pending bit drives the pin
   always_comb begin
      deliverable = '0;
      for (int i = 0; i < NIRQ; i++) begin
         deliverable[i] = q.pend[i] & ~q.rte[i][`MSD_RTE_MASK];
      end
   end

   // fixed priority: the lowest index wins, a busy low input can starve the rest
   assign pad_msg = 32'(deliverable);
   assign pad_ack = 32'(q.pend);
   assign pick_msg = msd_lowest(pad_msg);
   assign pick_ack = msd_lowest(pad_ack);

   // event block decode, shared by the write and the read paths
   function automatic logic evt_hit(input logic [15:0] a, input logic [15:0] off);
      return a == 16'(EVT_BASE + off);
   endfunction

   assign wr_nmi_sc = io_wr_i && (io_addr_i == `MSD_PORT_NMI_SC);
   assign wr_nmi_idx = io_wr_i && (io_addr_i == `MSD_PORT_NMI_IDX);
   assign wr_smi_en = io_wr_i && evt_hit(io_addr_i, `MSD_EVT_SMI_EN);
   assign wr_smi_sts = io_wr_i && evt_hit(io_addr_i, `MSD_EVT_SMI_STS);

   // enabled sleep trap status is the smi cause
   // only the sleep trap is wired as a cause; other sources would be ored in here
   assign smi_cause = q.slp_sts & q.sleep_entry_control;

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      d = q;
      d.irq_prev = irq_i;

      // redirection table load from the router configuration side
      // a load during a send leaves the captured message word untouched
      if (rte_wr_i) begin
         d.rte[rte_idx_i] = rte_wdata_i;
      end

      // pending bits: clears first, then new edges, so a set always wins
      // maskable_irq_pin_ack_i only counts in wire mode; messages clear on their own ack
      if (!router_en_i && maskable_irq_pin_ack_i && pick_ack[5]) begin
         d.pend[IDXW'(pick_ack[4:0])] = 1'b0;
      end
      if (q.st == MSD_SEND && msg_ack_i) begin
         d.pend[q.cur] = 1'b0;
      end
      d.pend = d.pend | edge_set;

      // wire mode drives the pin from any pending request
      // the pin follows the next pending vector, so it drops with the last bit
      d.maskable_irq_pin_pin = !router_en_i && (|d.pend);

      // message engine: flush, then one 32-bit write per interrupt
      // address and data are captured as the flush ends and held until the ack
      case (q.st)
         MSD_IDLE: begin
            if (router_en_i && pick_msg[5]) begin
               d.cur = IDXW'(pick_msg[4:0]);
               d.flush_req = 1'b1;
               d.st = MSD_FLUSH;
            end
         end
         MSD_FLUSH: begin
            // message may not overtake posted writes still upstream
            if (flush_done_i) begin
               d.flush_req = 1'b0;
               d.msg_wr = 1'b1;
               d.maddr = msg.addr;
               d.mdata = msg.data;
               d.st = MSD_SEND;
            end
         end
         MSD_SEND: begin
            if (msg_ack_i) begin
               d.msg_wr = 1'b0;
               d.st = MSD_IDLE;
            end
         end
         default: begin
            // unused encoding: drop both requests and go idle
            d.flush_req = 1'b0;
            d.msg_wr = 1'b0;
            d.st = MSD_IDLE;
         end
      endcase

      // nmi status and control port
      // an error in the same cycle as its clear wins, so no event is lost
      if (wr_nmi_sc) begin
         d.system_error_signal_en = io_wdata_i[`MSD_SYSTEM_ERROR_SIGNAL_EN_BIT];
         if (io_wdata_i[`MSD_SYSTEM_ERROR_SIGNAL_STS_BIT]) begin
            d.system_error_signal_sts = 1'b0;
         end
      end
      if (system_error_i) begin
         d.system_error_signal_sts = 1'b1;
      end

      // shared mask and rtc index port, write only
      if (wr_nmi_idx) begin
         d.nmi_idx = io_wdata_i[`MSD_PORT_BYTE];
      end

      // only the mask bit gates nmi, index bits are ignored here
      // built from registered state, so a mask write reaches the pin a cycle later
      d.nmi = !q.nmi_idx[`MSD_NMI_MASK_BIT] &&
              ((q.system_error_signal_sts && q.system_error_signal_en) || legacy_nmi_i);

      // smi trap enable
      if (wr_smi_en) begin
         d.sleep_entry_control = io_wdata_i[`MSD_SLP_BIT];
      end

      // sleep status: write one clears, a new sleep write wins
      if (wr_smi_sts && io_wdata_i[`MSD_SLP_BIT]) begin
         d.slp_sts = 1'b0;
      end
      if (sleep_entry_wr_i) begin
         d.slp_sts = 1'b1;
      end

      // smi assertion consumes the arm until end-of-smi
      // the pin is low exactly while the arm is spent
      if (q.armed && smi_cause) begin
         d.smi_n = 1'b0;
         d.armed = 1'b0;
      end
      // end-of-smi releases the pin and rearms; a still pending cause
      // fires again one cycle later, so the bit reads back cleared
      if (wr_smi_sts && io_wdata_i[`MSD_EOS_BIT]) begin
         d.smi_n = 1'b1;
         d.armed = 1'b1;
      end

      // read data, one cycle after the strobe; unmapped reads give zero
      // the write-only port 70h reads as zero like any unmapped port
      d.rdata = 32'h0000_0000;
      if (io_rd_i) begin
         case (io_addr_i)
            `MSD_PORT_NMI_SC: begin
               d.rdata[`MSD_SYSTEM_ERROR_SIGNAL_STS_BIT] = q.system_error_signal_sts;
               d.rdata[`MSD_SYSTEM_ERROR_SIGNAL_EN_BIT] = q.system_error_signal_en;
            end
            `MSD_PORT_IDX_RB: begin
               d.rdata[`MSD_RTC_IDX] = q.nmi_idx[`MSD_RTC_IDX];
            end
            default: begin
               if (evt_hit(io_addr_i, `MSD_EVT_SMI_EN)) begin
                  d.rdata[`MSD_SLP_BIT] = q.sleep_entry_control;
               end
               if (evt_hit(io_addr_i, `MSD_EVT_SMI_STS)) begin
                  d.rdata[`MSD_SLP_BIT] = q.slp_sts;
                  d.rdata[`MSD_EOS_BIT] = q.armed;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register, frozen while ce_i is low
   // held by enable rather than a gated clock, so timing stays simple

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NIRQ; i++) begin
            q.rte[i] <= `MSD_RTE_RST;
         end
         q.irq_prev <= '0;
         q.pend <= '0;
         q.st <= MSD_IDLE;
         q.cur <= '0;
         q.flush_req <= 1'b0;
         q.msg_wr <= 1'b0;
         q.maddr <= 32'h0000_0000;
         q.mdata <= 32'h0000_0000;
         q.maskable_irq_pin_pin <= 1'b0;
         q.nmi <= 1'b0;
         q.nmi_idx <= `MSD_NMI_IDX_RST;
         q.system_error_signal_en <= 1'b0;
         q.system_error_signal_sts <= 1'b0;
         q.sleep_entry_control <= 1'b0;
         q.slp_sts <= 1'b0;
         q.armed <= 1'b1;
         q.smi_n <= 1'b1;
         q.rdata <= 32'h0000_0000;
      end else if (ce_i) begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs, all straight from the state register
   // no decode sits between a flop and a pin, so the core sees no glitches

   assign io_rdata_o = q.rdata;
   assign flush_req_o = q.flush_req;
   assign msg_wr_o = q.msg_wr;
   assign msg_addr_o = q.maddr;
   assign msg_data_o = q.mdata;
   assign maskable_irq_pin_o = q.maskable_irq_pin_pin;
   assign nmi_o = q.nmi;
   assign smi_n_o = q.smi_n;

endmodule // msd_delivery

/* File: msd_consts.svh */
// constants for the interrupt, nmi and smi delivery block
`ifndef MSD_CONSTS_SVH
`define MSD_CONSTS_SVH
// i/o ports of the legacy nmi logic
`define MSD_PORT_NMI_SC 16'h0061
`define MSD_PORT_NMI_IDX 16'h0070
`define MSD_PORT_IDX_RB 16'h0074
// offsets inside the event block
`define MSD_EVT_SMI_EN 16'h0010
`define MSD_EVT_SMI_STS 16'h0014
`define MSD_EVT_BASE_RST 16'h1100
// bit positions
`define MSD_SLP_BIT 2
`define MSD_EOS_BIT 31
`define MSD_NMI_MASK_BIT 7
`define MSD_SYSTEM_ERROR_SIGNAL_EN_BIT 2
`define MSD_SYSTEM_ERROR_SIGNAL_STS_BIT 7
// reset values
`define MSD_NMI_IDX_RST 8'h80
`define MSD_RTE_RST 64'h0000_0000_0001_0000
// redirection entry fields
`define MSD_RTE_VEC 7:0
`define MSD_RTE_DLM 10:8
`define MSD_RTE_DSTM 11
`define MSD_RTE_TRIG 15
`define MSD_RTE_MASK 16
`define MSD_RTE_RH 48
`define MSD_RTE_DEST 63:56
// byte lanes of the legacy ports
`define MSD_PORT_BYTE 7:0
`define MSD_RTC_IDX 6:0
// message format constants
`define MSD_MSG_ADDR_TOP 12'hfee
`define MSD_MSG_ASSERT 1'b1
`define MSD_MAX_IRQ 32
`endif

/* File: msd_pkg.sv */
// types and helpers shared by the delivery block
package msd_pkg;
   // message engine states
   typedef enum logic [1:0] {
      MSD_IDLE,
      MSD_FLUSH,
      MSD_SEND
   } msd_state_e;

   typedef logic [63:0] msd_rte_t;

   // lowest set bit of a request vector, index in low bits, found flag on top
   function automatic logic [5:0] msd_lowest(input logic [31:0] v);
      logic [5:0] r;
      r = 6'h00;
      for (int i = 31; i >= 0; i--) begin
         if (v[i]) begin
            r = {1'b1, 5'(i)};
         end
      end
      return r;
   endfunction
endpackage

/* File: msd_msg_if.sv */
// carrier between the message engine and the message formatter
`timescale 1ns/10ps
interface msd_msg_if;
   logic [63:0] rte;
   logic [31:0] addr;
   logic [31:0] data;
   modport fmt (input rte, output addr, output data);
   modport user (output rte, input addr, input data);
endinterface

/* File: msd_msg_fmt.sv */
// builds message address and data from a redirection entry
`timescale 1ns/10ps
`include "msd_consts.svh"
module msd_msg_fmt
   import msd_pkg::*;
(
   msd_msg_if.fmt m
);
   // address: fixed top, destination, zero gap, hint, dest mode, zero
   assign m.addr = {`MSD_MSG_ADDR_TOP, m.rte[`MSD_RTE_DEST], 8'h00,
                    m.rte[`MSD_RTE_RH], m.rte[`MSD_RTE_DSTM], 2'b00};
   // data: zero top, trigger, assert status, zero, delivery mode, vector
   assign m.data = {16'h0000, m.rte[`MSD_RTE_TRIG],
                    `MSD_MSG_ASSERT, 3'b000,
                    m.rte[`MSD_RTE_DLM], m.rte[`MSD_RTE_VEC]};
endmodule // msd_msg_fmt

/* File: msd_cpu_model.sv */
// processor side model: takes flush requests and interrupt message writes
`timescale 1ns/10ps
module msd_cpu_model (
   input wire logic clk_i,
   input wire logic slow_i,
   input wire logic flush_req_i,
   input wire logic msg_wr_i,
   input wire logic [31:0] msg_addr_i,
   input wire logic [31:0] msg_data_i,
   output logic flush_done_o,
   output logic msg_ack_o,
   output logic [31:0] got_addr_o,
   output logic [31:0] got_data_o,
   output int msg_cnt_o
);
   logic fd_q = 1'b0;
   logic ack_q = 1'b0;
   int wait_q = 0;
   int cnt_q = 0;
   // one process owns each flag; the ports only mirror it
   assign flush_done_o = fd_q;
   assign msg_ack_o = ack_q;
   assign msg_cnt_o = cnt_q;
   ////////////////////////////////////////
   // one answer per request; slow mode stalls three cycles to stretch both handshakes
   always @(posedge clk_i) begin
      fd_q <= 1'b0;
      ack_q <= 1'b0;
      if ((flush_req_i && !fd_q) || (msg_wr_i && !ack_q)) begin
         wait_q <= wait_q + 1;
         if (wait_q >= (slow_i ? 3 : 0)) begin
            wait_q <= 0;
            fd_q <= flush_req_i;
            ack_q <= msg_wr_i && !flush_req_i;
            if (msg_wr_i && !flush_req_i) begin
               got_addr_o <= msg_addr_i;
               got_data_o <= msg_data_i;
               cnt_q <= cnt_q + 1;
            end
         end
      end
   end
endmodule // msd_cpu_model

/* File: msd_delivery_sva.sv */
// port checker for the delivery block
`timescale 1ns/10ps
module msd_delivery_sva
   import msd_pkg::*;
#(
   parameter logic [15:0] EVT_BASE = 16'h1100
) (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic [15:0] io_addr_i,
   input wire logic io_wr_i,
   input wire logic io_rd_i,
   input wire logic [31:0] io_wdata_i,
   input wire logic [31:0] io_rdata_o,
   input wire logic router_en_i,
   input wire logic flush_req_o,
   input wire logic flush_done_i,
   input wire logic msg_wr_o,
   input wire logic [31:0] msg_addr_o,
   input wire logic [31:0] msg_data_o,
   input wire logic msg_ack_i,
   input wire logic legacy_nmi_i,
   input wire logic nmi_o,
   input wire logic sleep_entry_wr_i,
   input wire logic smi_n_o
);
   logic mask_q;
   logic trap_q;
   logic [6:0] idx_q;
   wire logic end_of_smi_bit = io_wr_i && io_addr_i == EVT_BASE + 16'h0014 && io_wdata_i[31];
   default clocking cb @(posedge mclk_i);
   endclocking
   // a frozen design proves nothing, so checks pause while ce_i is low
   default disable iff (!nrst_i || !ce_i);
   ////////////////////////////////////////
   // shadow of mask, index and trap enable; only the mask bit is never shown at a port
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mask_q <= 1'b1;
         idx_q <= 7'h00;
         trap_q <= 1'b0;
      end else if (ce_i) begin
         if (io_wr_i && io_addr_i == 16'h0070) begin
            mask_q <= io_wdata_i[7];
            idx_q <= io_wdata_i[6:0];
         end
         if (io_wr_i && io_addr_i == EVT_BASE + 16'h0010) begin
            trap_q <= io_wdata_i[2];
         end
      end
   end
   ////////////////////////////////////////
   sequence s_sleep;
      sleep_entry_wr_i && trap_q && smi_n_o;
   endsequence
   property p_addr;
      msg_wr_o |-> msg_addr_o[31:20] == 12'hfee && msg_addr_o[11:4] == 8'h00
         && msg_addr_o[1:0] == 2'h0;
   endproperty
   property p_data;
      msg_wr_o |-> msg_data_o[31:16] == 16'h0 && msg_data_o[14] && msg_data_o[13:11] == 3'h0;
   endproperty
   property p_flush;
      $rose(msg_wr_o) |-> $past(flush_done_i);
   endproperty
   property p_hold;
      msg_wr_o && !msg_ack_i |=> msg_wr_o && $stable(msg_addr_o) && $stable(msg_data_o);
   endproperty
   property p_mode;
      $rose(flush_req_o) |-> $past(router_en_i);
   endproperty
   property p_mask;
      mask_q |=> !nmi_o;
   endproperty
   property p_legacy;
      legacy_nmi_i && !mask_q |=> nmi_o;
   endproperty
   property p_rb;
      io_rd_i && io_addr_i == 16'h0074 |=> io_rdata_o == {25'h0, $past(idx_q)};
   endproperty
   property p_fhold;
      flush_req_o && !flush_done_i |=> flush_req_o;
   endproperty
   property p_smi_hold;
      !smi_n_o && !end_of_smi_bit |=> !smi_n_o;
   endproperty
   property p_eos;
      end_of_smi_bit |=> smi_n_o;
   endproperty
   property p_sleep;
      s_sleep |-> ##2 !smi_n_o;
   endproperty
   a_addr: assert property (p_addr) else $error("bad message address");
   a_data: assert property (p_data) else $error("bad message data");
   a_flush: assert property (p_flush) else $error("message before flush");
   a_hold: assert property (p_hold) else $error("message dropped early");
   a_mode: assert property (p_mode) else $error("message in wire mode");
   a_mask: assert property (p_mask) else $error("nmi while masked");
   a_legacy: assert property (p_legacy) else $error("nmi missing");
   a_rb: assert property (p_rb) else $error("index readback wrong");
   a_eos: assert property (p_eos) else $error("smi not released");
   a_sleep: assert property (p_sleep) else $error("sleep smi missing");
   a_fhold: assert property (p_fhold) else $error("flush request dropped early");
   a_smi_hold: assert property (p_smi_hold) else $error("smi released early");
endmodule // msd_delivery_sva

bind msd_delivery msd_delivery_sva #(.EVT_BASE(EVT_BASE)) u_sva (.*);

/* File: msd_delivery_tb.sv */
// self-checking bench for the delivery block
`timescale 1ns/10ps
module msd_delivery_tb
   import msd_pkg::*;
;
   localparam logic [15:0] EV = 16'h1100;
   logic mclk_i, nrst_i, ce_i, io_wr_i, io_rd_i, rte_wr_i, router_en_i, maskable_irq_pin_ack_i, slow;
   logic system_error_i, legacy_nmi_i, sleep_entry_wr_i, flush_done_i, msg_ack_i;
   logic flush_req_o, msg_wr_o, maskable_irq_pin_o, nmi_o, smi_n_o;
   logic [15:0] io_addr_i;
   logic [31:0] io_wdata_i, io_rdata_o, msg_addr_o, msg_data_o, got_a, got_d, sv;
   logic [2:0] rte_idx_i;
   logic [63:0] rte_wdata_i;
   logic [7:0] irq_i;
   int fails, samples_checked, cnt;
   msd_delivery #(.EVT_BASE(EV)) dut (.*);
   msd_cpu_model cpu (.clk_i(mclk_i), .slow_i(slow), .flush_req_i(flush_req_o),
      .msg_wr_i(msg_wr_o), .msg_addr_i(msg_addr_o), .msg_data_i(msg_data_o),
      .flush_done_o(flush_done_i), .msg_ack_o(msg_ack_i), .got_addr_o(got_a),
      .got_data_o(got_d), .msg_cnt_o(cnt));
   ////////////////////////////////////////
   function automatic logic [31:0] ea(input logic [63:0] e);
      return {12'hfee, e[63:56], 8'h00, e[48], e[11], 2'b00};
   endfunction
   function automatic logic [31:0] ed(input logic [63:0] e);
      return {16'h0, e[15], 1'b1, 3'b0, e[10:8], e[7:0]};
   endfunction
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic c1(input string nm, input logic got, exp);
      chk(nm, {31'h0, got}, {31'h0, exp});
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask
   // every bus task ends one idle cycle later, so strobes never toggle twice at once
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      {io_addr_i, io_wdata_i, io_wr_i} = {a, d, 1'b1};
      tick(1);
      io_wr_i = 1'b0;
      tick(1);
   endtask
   task automatic rdc(input string nm, input logic [15:0] a, input logic [31:0] exp);
      {io_addr_i, io_rd_i} = {a, 1'b1};
      tick(1);
      io_rd_i = 1'b0;
      chk(nm, io_rdata_o, exp);
      sv = io_rdata_o;
      tick(1);
   endtask
   task automatic rte(input logic [2:0] i, input logic [63:0] v);
      {rte_idx_i, rte_wdata_i, rte_wr_i} = {i, v, 1'b1};
      tick(1);
      rte_wr_i = 1'b0;
      tick(1);
   endtask
   task automatic pulse_sleep();
      sleep_entry_wr_i = 1'b1;
      tick(1);
      sleep_entry_wr_i = 1'b0;
      tick(2);
   endtask
   task automatic wcnt(input int n);
      for (int i = 0; i < 50 && cnt < n; i++) begin
         tick(1);
      end
      chk("count", 32'(cnt), 32'(n));
      if (cnt < n) begin
         complete_run();
      end
   endtask
   ////////////////////////////////////////
   task automatic t_regs();
      c1("smi", smi_n_o, 1'b1);
      rdc("idx", 16'h0074, 32'h0);
      rdc("wo", 16'h0070, 32'h0);
      rdc("eos", EV + 16'h0014, 32'h8000_0000);
      rdc("gap", 16'h0099, 32'h0);
   endtask
   task automatic t_nmi();
      legacy_nmi_i = 1'b1;
      tick(2);
      c1("nmi", nmi_o, 1'b0);
      wr(16'h0070, 32'h55);
      c1("nmi", nmi_o, 1'b1);
      rdc("idx", 16'h0074, 32'h55);
      ce_i = 1'b0;
      legacy_nmi_i = 1'b0;
      tick(3);
      c1("frozen", nmi_o, 1'b1);
      ce_i = 1'b1;
      legacy_nmi_i = 1'b1;
      wr(16'h0070, 32'h2a);
      c1("nmi", nmi_o, 1'b1);
      wr(16'h0070, 32'hff);
      c1("nmi", nmi_o, 1'b0);
      legacy_nmi_i = 1'b0;
      wr(16'h0070, 32'h13);
      system_error_i = 1'b1;
      tick(1);
      system_error_i = 1'b0;
      tick(2);
      c1("nmi", nmi_o, 1'b0);
      rdc("system_error_signal", 16'h0061, 32'h80);
      wr(16'h0061, 32'h4);
      c1("nmi", nmi_o, 1'b1);
      // handler order: save index, mask, clear status, restore
      rdc("idx", 16'h0074, 32'h13);
      wr(16'h0070, sv | 32'h80);
      c1("nmi", nmi_o, 1'b0);
      wr(16'h0061, 32'h84);
      wr(16'h0070, sv);
      c1("nmi", nmi_o, 1'b0);
      rdc("idx", 16'h0074, 32'h13);
   endtask
   task automatic t_wire();
      rte(3'd1, 64'h0);
      irq_i = 8'h02;
      tick(4);
      c1("pin", maskable_irq_pin_o, 1'b1);
      maskable_irq_pin_ack_i = 1'b1;
      tick(1);
      maskable_irq_pin_ack_i = 1'b0;
      tick(3);
      c1("pin", maskable_irq_pin_o, 1'b0);
      chk("wire", 32'(cnt), 32'd0);
      irq_i = 8'h00;
   endtask
   task automatic t_msg();
      logic [63:0] e [3];
      e = '{64'h5a01_0000_0000_8d47, 64'h0300_0000_0000_02fe, 64'h7700_0000_0001_0133};
      router_en_i = 1'b1;
      slow = 1'b1;
      for (int k = 0; k < 3; k++) begin
         rte(3'(k + 4), e[k]);
      end
      irq_i = 8'h70;
      for (int k = 0; k < 3; k++) begin
         if (k == 2) begin
            tick(12);
            chk("held", 32'(cnt), 32'd2);
            slow = 1'b0;
            rte(3'd6, e[2] ^ 64'h1_0000);
         end
         wcnt(k + 1);
         chk("addr", got_a, ea(e[k]));
         chk("data", got_d, ed(e[k]));
      end
      irq_i = 8'h00;
   endtask
   task automatic t_smi();
      wr(EV + 16'h0010, 32'h4);
      pulse_sleep();
      c1("smi", smi_n_o, 1'b0);
      rdc("sts", EV + 16'h0014, 32'h4);
      // the release stands for one cycle only, so look before the retrigger
      {io_addr_i, io_wdata_i, io_wr_i} = {EV + 16'h0014, 32'h8000_0000, 1'b1};
      tick(1);
      io_wr_i = 1'b0;
      c1("smi", smi_n_o, 1'b1);
      tick(1);
      c1("smi", smi_n_o, 1'b0);
      rdc("sts", EV + 16'h0014, 32'h4);
      wr(EV + 16'h0014, 32'h8000_0004);
      tick(2);
      c1("smi", smi_n_o, 1'b1);
      rdc("sts", EV + 16'h0014, 32'h8000_0000);
      wr(EV + 16'h0010, 32'h0);
      pulse_sleep();
      c1("smi", smi_n_o, 1'b1);
      rdc("sts", EV + 16'h0014, 32'h8000_0004);
      wr(EV + 16'h0014, 32'h4);
   endtask
   ////////////////////////////////////////
   initial begin
      mclk_i = 1'b0;
      forever #2 mclk_i = ~mclk_i;
   end
   initial begin
      {fails, samples_checked} = 64'h0;
      {nrst_i, ce_i, io_wr_i, io_rd_i, rte_wr_i, router_en_i, maskable_irq_pin_ack_i, slow} = 8'h40;
      {system_error_i, legacy_nmi_i, sleep_entry_wr_i, irq_i} = 11'h0;
      {io_addr_i, io_wdata_i, rte_idx_i, rte_wdata_i} = '0;
      repeat (20) @(posedge mclk_i);
      #1 nrst_i = 1'b1;
      tick(3);
      t_regs();
      t_nmi();
      t_wire();
      t_msg();
      t_smi();
      complete_run();
   end
endmodule // msd_delivery_tb
